// file: adc_seq_cfg.svh
// Purpose: constants of the round-robin adc sequencer
// Assumes: clk_sys at 40 MHz, times given in ns
// Notes: cycle counts are derived from the times below
// Behaviour
// - compare voltage readings with per-channel limits
// - status bit: 0 in limits, 1 outside
// - set status raises alert when enabled
// - battery lower leg only during battery conversion
// - average 16 conversions per reading
// - battery channel uses one unaveraged conversion
// - battery measurement occupies about 711 us
// - multiplexer steps enabled inputs round robin
// - slots: local 9.01, remote 38.36, voltage 8.53 ms
// - cycle length is sum of enabled slots
// - fan speed never enters converter sequence
// - attenuator bypass bits per channel
// - select bit 2 enables single-channel mode
// - single channel code from select bits 7:3
// - fixed channel code to input mapping
// - single mode converts selected channel continuously
// - ten-bit converter shared through the multiplexer
// - status sticky until read and condition gone
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
// timing
`define CLK_NS      25
`define T_LOCAL_NS  9010000
`define T_REMOTE_NS 38360000
`define T_VOLT_NS   8530000
`define T_BATT_NS   711000
`define TMR_W       21
// averaging
`define AVG_N       5'h10
// register offsets
`define A_SEL       8'h16
`define A_ATT1      8'h18
`define A_ATT2      8'h19
`define A_LO        8'h20
`define A_HI        8'h40
`define A_VAL       8'h60
`define A_ST0       8'h80
`define A_ST1       8'h81
`define A_ST2       8'h82
`define A_ACFG      8'h83
// fields and codes
`define SEL_EN      2
`define NCH         18
`define CH_VALID    18'h37FFF
`define CH_BATT     5'h00
`define CH_REM_LO   5'h01
`define CH_REM_HI   5'h03
`define CH_LOCAL    5'h04
// reset values
`define LO_RST      8'h00
`define HI_RST      8'hFF
`endif

// file: adc_seq_pkg.sv
// Purpose: types of the adc sequencer
// Assumes: nothing
// Notes: no constants here, see adc_seq_cfg.svh
package adc_seq_pkg;
  typedef enum logic [1:0] {ST_PICK, ST_CONV, ST_STORE, ST_WAIT} seq_state_t;
  typedef logic [4:0] chan_t;
endpackage

// file: slot_timer.sv
// Purpose: down counter that times one channel slot
// Assumes: load has priority over counting
// Notes: done is high while the count is zero
module slot_timer #(
  parameter int W = 21
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);
  logic [W-1:0] cnt_q; // remaining cycles
  logic [W-1:0] cnt_d;

  // next count
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // count register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == '0);
endmodule // slot_timer

// file: sample_acc.sv
// Purpose: sums converter samples of one reading
// Assumes: at most 16 samples per reading
// Notes: clear has priority over add
module sample_acc #(
  parameter int DW = 10,
  parameter int SW = 14
) (
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  input  wire logic          clr,
  input  wire logic          add,
  input  wire logic [DW-1:0] din,
  output logic      [SW-1:0] sum_q
);
  logic [SW-1:0] sum_d;

  // next sum
  always_comb begin
    sum_d = sum_q;
    if (clr) begin
      sum_d = '0;
    end else if (add) begin
      sum_d = sum_q + SW'(din);
    end
  end

  // sum register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sum_q <= '0;
    end else begin
      sum_q <= sum_d;
    end
  end
endmodule // sample_acc

// file: adc_round_robin_sequencer.sv
// Purpose: sequencing, averaging and limit check around a shared adc
// Assumes: register port and converter handshake synchronous to clk_sys
// Notes: limits compare against the upper eight result bits
`include "adc_seq_cfg.svh"
module adc_round_robin_sequencer #(
  parameter int LOCAL_CYC  = `T_LOCAL_NS / `CLK_NS,
  parameter int REMOTE_CYC = `T_REMOTE_NS / `CLK_NS,
  parameter int VOLT_CYC   = `T_VOLT_NS / `CLK_NS,
  parameter int BATT_CYC   = `T_BATT_NS / `CLK_NS
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata_q,
  input  wire logic [17:0] chan_enable,
  input  wire logic        batt_mode,
  input  wire logic [9:0]  conv_data,
  input  wire logic        conv_done,
  output logic      [4:0]  mux_sel_q,
  output logic             conv_start_q,
  output logic             batt_leg_q,
  output logic      [15:0] atten_bypass_q,
  output logic             alert_n_q
);
  ////////////////////////////////////////////////////////////////
  // channel decode helpers
  localparam logic [17:0] ASSIGNED_CODES = `CH_VALID;  // one bit per assigned code
  // code is assigned to an input
  function automatic logic chan_ok(adc_seq_pkg::chan_t c);
    chan_ok = (c < 5'(`NCH)) && ASSIGNED_CODES[c];
  endfunction

  // code names a temperature channel
  function automatic logic is_temp(adc_seq_pkg::chan_t c);
    is_temp = (c >= `CH_REM_LO) && (c <= `CH_LOCAL);
  endfunction

  // slot length of a channel
  function automatic logic [`TMR_W-1:0] slot_len(adc_seq_pkg::chan_t c,
                                                 logic bat);
    if (c == `CH_LOCAL) begin
      slot_len = `TMR_W'(LOCAL_CYC);
    end else if (is_temp(c)) begin
      slot_len = `TMR_W'(REMOTE_CYC);
    end else if (bat && c == `CH_BATT) begin
      slot_len = `TMR_W'(BATT_CYC);
    end else begin
      slot_len = `TMR_W'(VOLT_CYC);
    end
  endfunction

  // next enabled channel after cur, wrapping
  function automatic adc_seq_pkg::chan_t next_chan(adc_seq_pkg::chan_t cur,
                                                   logic [17:0] en);
    logic found;
    int   k;
    found = 1'b0;
    next_chan = cur;
    for (int i = 1; i <= `NCH; i++) begin
      k = (int'(cur) + i) % `NCH;
      if (!found && en[k]) begin
        found = 1'b1;
        next_chan = 5'(k);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // declarations
  adc_seq_pkg::seq_state_t st_q, st_d;  // sequencer state
  adc_seq_pkg::chan_t      mux_d;       // next multiplexer code
  adc_seq_pkg::chan_t      pick_ch;     // channel chosen in pick
  logic                    pick_go;     // a channel can be converted
  logic                    start_d;
  logic                    batt_d;
  logic [4:0]              n_q, n_d;    // samples taken
  logic [4:0]              need;        // samples per reading
  logic                    acc_clr;
  logic                    acc_add;
  logic [13:0]             acc_sum;
  logic                    tmr_ld;
  logic                    tmr_done;
  logic                    store;       // reading complete
  logic [9:0]              res10;       // averaged reading
  logic [7:0]              res8;        // compared part
  logic                    oor_now;     // reading out of limits
  logic                    single;      // single-channel mode
  logic [17:0]             en_rr;       // enabled, assigned codes
  // register file
  logic [7:0]  sel_q, sel_d;
  logic [7:0]  att1_q, att1_d;
  logic [7:0]  att2_q, att2_d;
  logic [7:0]  acfg_q, acfg_d;
  logic [7:0]  lo_q [`NCH];
  logic [7:0]  lo_d [`NCH];
  logic [7:0]  hi_q [`NCH];
  logic [7:0]  hi_d [`NCH];
  logic [7:0]  val_q [`NCH];
  logic [7:0]  val_d [`NCH];
  logic [17:0] oor_q, oor_d;   // live limit condition
  logic [17:0] stat_q, stat_d; // sticky status
  logic [17:0] st_set, st_clr;
  logic [7:0]  rdata_d;
  logic        alert_n_d;
  logic [4:0]  lo_ix, hi_ix, val_ix;
  logic        lo_hit, hi_hit, val_hit; // address inside a table

  // full eight-bit range check, so one table never aliases into another
  assign lo_hit  = (reg_addr >= `A_LO) && (reg_addr < `A_LO + 8'(`NCH));
  assign hi_hit  = (reg_addr >= `A_HI) && (reg_addr < `A_HI + 8'(`NCH));
  assign val_hit = (reg_addr >= `A_VAL) && (reg_addr < `A_VAL + 8'(`NCH));
  assign single = sel_q[`SEL_EN];
  assign en_rr  = chan_enable & `CH_VALID;
  assign need   = batt_leg_q ? 5'h01 : `AVG_N;
  // battery reading is one raw sample, others sum of 16 shifted down
  assign res10  = batt_leg_q ? acc_sum[9:0] : acc_sum[13:4];
  assign res8   = res10[9:2];
  assign oor_now = (res8 > hi_q[mux_sel_q]) || (res8 < lo_q[mux_sel_q]);

  ////////////////////////////////////////////////////////////////
  // slot timer and accumulator
  slot_timer #(.W(`TMR_W)) i_slot_timer (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .load     (tmr_ld),
    .load_val (slot_len(pick_ch, batt_mode)),
    .done     (tmr_done)
  );

  sample_acc #(.DW(10), .SW(14)) i_sample_acc (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clr     (acc_clr),
    .add     (acc_add),
    .din     (conv_data),
    .sum_q   (acc_sum)
  );

  ////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    st_d = st_q;
    mux_d = mux_sel_q;
    start_d = 1'b0;
    batt_d = batt_leg_q;
    n_d = n_q;
    acc_clr = 1'b0;
    acc_add = 1'b0;
    tmr_ld = 1'b0;
    store = 1'b0;
    // choose the channel: selected one, or next enabled in turn
    if (single) begin
      pick_ch = sel_q[7:3];
      pick_go = chan_ok(sel_q[7:3]);
    end else begin
      pick_ch = next_chan(mux_sel_q, en_rr);
      pick_go = |en_rr;
    end
    unique case (st_q)
      // select input and start first sample
      adc_seq_pkg::ST_PICK: begin
        batt_d = 1'b0;
        if (pick_go) begin
          st_d = adc_seq_pkg::ST_CONV;
          mux_d = pick_ch;
          start_d = 1'b1;
          batt_d = (pick_ch == `CH_BATT) && batt_mode;
          n_d = 5'h00;
          acc_clr = 1'b1;
          tmr_ld = !single;
        end
      end
      // collect samples until the reading is complete
      adc_seq_pkg::ST_CONV: begin
        if (conv_done) begin
          acc_add = 1'b1;
          n_d = 5'(n_q + 5'h01);
          if (5'(n_q + 5'h01) == need) begin
            st_d = adc_seq_pkg::ST_STORE;
          end else begin
            start_d = 1'b1;
          end
        end
      end
      // write result; single mode goes straight on
      adc_seq_pkg::ST_STORE: begin
        store = 1'b1;
        st_d = single ? adc_seq_pkg::ST_PICK : adc_seq_pkg::ST_WAIT;
      end
      // fill rest of slot, then release battery leg
      adc_seq_pkg::ST_WAIT: begin
        if (tmr_done) begin
          st_d = adc_seq_pkg::ST_PICK;
          batt_d = 1'b0;
        end
      end
    endcase
  end

  // sequencer registers; fan speed has no slot here
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= adc_seq_pkg::ST_PICK;
      mux_sel_q <= 5'h11;
      conv_start_q <= 1'b0;
      batt_leg_q <= 1'b0;
      n_q <= 5'h00;
    end else begin
      st_q <= st_d;
      mux_sel_q <= mux_d;
      conv_start_q <= start_d;
      batt_leg_q <= batt_d;
      n_q <= n_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // register file next state
  always_comb begin
    sel_d = sel_q;
    att1_d = att1_q;
    att2_d = att2_q;
    acfg_d = acfg_q;
    lo_d = lo_q;
    hi_d = hi_q;
    val_d = val_q;
    oor_d = oor_q;
    st_set = '0;
    st_clr = '0;
    rdata_d = 8'h00;
    lo_ix = 5'(reg_addr - `A_LO);
    hi_ix = 5'(reg_addr - `A_HI);
    val_ix = 5'(reg_addr - `A_VAL);
    // software writes
    if (reg_wr) begin
      if (reg_addr == `A_SEL) sel_d = reg_wdata;
      if (reg_addr == `A_ATT1) att1_d = reg_wdata;
      if (reg_addr == `A_ATT2) att2_d = reg_wdata;
      if (reg_addr == `A_ACFG) acfg_d = reg_wdata;
      if (lo_hit) lo_d[lo_ix] = reg_wdata;
      if (hi_hit) hi_d[hi_ix] = reg_wdata;
    end
    // software reads; status read clears bits whose cause is gone
    if (reg_rd) begin
      if (reg_addr == `A_SEL) rdata_d = sel_q;
      if (reg_addr == `A_ATT1) rdata_d = att1_q;
      if (reg_addr == `A_ATT2) rdata_d = att2_q;
      if (reg_addr == `A_ACFG) rdata_d = acfg_q;
      if (lo_hit) rdata_d = lo_q[lo_ix];
      if (hi_hit) rdata_d = hi_q[hi_ix];
      if (val_hit) rdata_d = val_q[val_ix];
      if (reg_addr == `A_ST0) begin
        rdata_d = stat_q[7:0];
        st_clr[7:0] = ~oor_q[7:0];
      end
      if (reg_addr == `A_ST1) begin
        rdata_d = stat_q[15:8];
        st_clr[15:8] = ~oor_q[15:8];
      end
      if (reg_addr == `A_ST2) begin
        rdata_d = {6'h00, stat_q[17:16]};
        st_clr[17:16] = ~oor_q[17:16];
      end
    end
    // completed reading: store value, check voltage limits
    if (store) begin
      val_d[mux_sel_q] = res8;
      if (!is_temp(mux_sel_q)) begin
        oor_d[mux_sel_q] = oor_now;
        st_set[mux_sel_q] = oor_now;
      end
    end
    // a new out-of-limit result wins over a clearing read
    stat_d = (stat_q & ~st_clr) | st_set;
    alert_n_d = !(acfg_q[0] && (|stat_q));
  end

  // register file registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sel_q <= 8'h00;
      att1_q <= 8'h00;
      att2_q <= 8'h00;
      acfg_q <= 8'h00;
      lo_q <= '{default: `LO_RST};
      hi_q <= '{default: `HI_RST};
      val_q <= '{default: 8'h00};
      oor_q <= '0;
      stat_q <= '0;
      reg_rdata_q <= 8'h00;
      alert_n_q <= 1'b1;
      atten_bypass_q <= 16'h0000;
    end else begin
      sel_q <= sel_d;
      att1_q <= att1_d;
      att2_q <= att2_d;
      acfg_q <= acfg_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      val_q <= val_d;
      oor_q <= oor_d;
      stat_q <= stat_d;
      reg_rdata_q <= rdata_d;
      alert_n_q <= alert_n_d;
      atten_bypass_q <= {att2_q, att1_q};
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_single_pick;
    st_q == adc_seq_pkg::ST_PICK && single && chan_ok(sel_q[7:3]);
  endsequence

  sequence s_store_volt_bad;
    store && !is_temp(mux_sel_q) && oor_now;
  endsequence

  a_batt_leg_gate: assert property (
    batt_leg_q |-> (mux_sel_q == `CH_BATT) && batt_mode)
    else $error("battery leg on outside battery slot");
  a_batt_one_sample: assert property (
    store && batt_leg_q |-> n_q == 5'h01)
    else $error("battery reading not a single sample");
  a_avg_sixteen: assert property (
    store && !batt_leg_q |-> n_q == 5'h10)
    else $error("reading not from 16 samples");
  a_status_set: assert property (
    s_store_volt_bad |=> stat_q[$past(mux_sel_q)] && oor_q[$past(mux_sel_q)])
    else $error("out-of-limit reading left status clear");
  a_alert_follow: assert property (
    acfg_q[0] && (|stat_q) |=> !alert_n_q)
    else $error("alert not raised for set status");
  a_single_chan: assert property (
    s_single_pick |=> conv_start_q && mux_sel_q == $past(sel_q[7:3]))
    else $error("single mode converted wrong channel");
  a_bad_code_idle: assert property (
    st_q == adc_seq_pkg::ST_PICK && single && !chan_ok(sel_q[7:3])
    |=> !conv_start_q && st_q == adc_seq_pkg::ST_PICK)
    else $error("unassigned code started a conversion");
  a_sticky_hold: assert property (
    !(reg_rd && (reg_addr == `A_ST0 || reg_addr == `A_ST1 || reg_addr == `A_ST2))
    |=> (stat_q & $past(stat_q)) == $past(stat_q))
    else $error("status bit dropped without read");
endmodule // adc_round_robin_sequencer

// file: adc_conv_model.sv
// Purpose: behavioural converter that answers the sequencer start pulses
// Assumes: only one conversion is outstanding at a time
// Notes: latency is 1 to 4 cycles; data inverts every cycle outside done, so it repeats the last result every other cycle
module adc_conv_model (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       conv_start,
  input  wire logic [9:0] sample_val,
  output logic      [9:0] conv_data,
  output logic            conv_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int   wait_cnt; // cycles left in the conversion
  logic busy;     // a conversion is outstanding
  initial begin
    conv_data = 10'h000;
    conv_done = 1'b0;
    busy      = 1'b0;
    wait_cnt  = 0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one ten-bit result per start pulse, prompt or slow
  always @(posedge clk_sys) begin
    conv_done <= 1'b0;
    if (sys_rst) begin
      busy = 1'b0;
    end else if (busy && wait_cnt == 0) begin
      conv_done <= 1'b1;
      conv_data <= sample_val;
      busy = 1'b0;
    end else begin
      wait_cnt = wait_cnt - 1;
      conv_data <= ~conv_data; // not valid outside done
    end
    if (conv_start) begin
      busy = 1'b1;
      wait_cnt = $urandom_range(3, 0);
    end
  end
endmodule // adc_conv_model

// file: adc_round_robin_sequencer_tb_top.sv
// Purpose: self-checking bench of the round-robin adc sequencer
// Assumes: short slot times through the parameters
// Notes: register reads are noted in a queue and compared by a watcher
module adc_round_robin_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int VOLT_CYC = 150; // shortened voltage slot
  localparam int BATT_CYC = 40;  // shortened battery slot
  logic        clk_sys, sys_rst, reg_wr, reg_rd, batt_mode, conv_done, conv_start_q;
  logic        batt_leg_q, alert_n_q, rd_seen, rr_on;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_q, att_a, att_b;
  logic [17:0] chan_enable;
  logic [9:0]  conv_data, sample_val, d;
  logic [4:0]  mux_sel_q, cur;
  logic [15:0] atten_bypass_q;
  logic [7:0]  exp_q[$];   // expected read data, oldest first
  int          num_errors, num_checks, n_start, slot_starts, slot_len, slots_seen, seed;
  adc_round_robin_sequencer #(.LOCAL_CYC(200), .REMOTE_CYC(400), .VOLT_CYC(VOLT_CYC),
    .BATT_CYC(BATT_CYC)) i_adc_round_robin_sequencer (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .chan_enable(chan_enable), .batt_mode(batt_mode), .conv_data(conv_data),
    .conv_done(conv_done), .mux_sel_q(mux_sel_q), .conv_start_q(conv_start_q),
    .batt_leg_q(batt_leg_q), .atten_bypass_q(atten_bypass_q), .alert_n_q(alert_n_q));
  adc_conv_model i_adc_conv_model (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .conv_start(conv_start_q),
    .sample_val(sample_val), .conv_data(conv_data), .conv_done(conv_done));
  //////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////////////
  // compare, register cycles, waits, verdict
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // next enabled code after c, wrapping past code 17
  function automatic logic [4:0] nxt(input logic [4:0] c);
    logic [4:0] k;
    k = c;
    for (int i = 0; i < 18; i++) begin
      k = (k == 5'h11) ? 5'h00 : k + 5'h01;
      if (chan_enable[k]) return k;
    end
    return c;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // read watcher: data stands the cycle after the strobe
  always @(negedge clk_sys) begin
    if (rd_seen) chk(18'(reg_rdata_q), 18'(exp_q.pop_front()));
    rd_seen = reg_rd;
  end
  //////////////////////////////////////////////////////////////////////////////
  // slot watcher: starts, length and order of each round-robin slot
  always @(posedge clk_sys) begin
    n_start += int'(conv_start_q);
    if (rr_on && batt_leg_q) chk(18'(mux_sel_q), 18'h00000);
    if (mux_sel_q !== cur) begin
      if (rr_on && slots_seen > 1) begin
        chk(18'(slot_starts), (cur == 5'h00) ? 18'h00001 : 18'h00010);
        chk(18'(slot_len >= ((cur == 5'h00) ? BATT_CYC : VOLT_CYC) - 1 &&
            slot_len <= ((cur == 5'h00) ? BATT_CYC : VOLT_CYC) + 4), 18'h1);
        chk(18'(mux_sel_q), 18'(nxt(cur)));
      end
      slots_seen++;
      cur = mux_sel_q;
      slot_starts = 0;
      slot_len = 0;
    end
    slot_starts += int'(conv_start_q);
    slot_len++;
  end
  //////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    test_done;
  end
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = $urandom(78);
    {reg_wr, reg_rd, rd_seen, rr_on, batt_mode} = 5'h00;
    {reg_addr, reg_wdata, chan_enable, sample_val} = '0;
    {num_errors, num_checks, n_start, slot_starts, slot_len, slots_seen} = '0;
    cur = 5'h11;
    sys_rst = 1'b1;
    cyc(10);
    sys_rst <= 1'b0;
    cyc(1);
    chk(18'(alert_n_q), 18'h1);
    rd(8'h25, 8'h00);
    rd(8'h45, 8'hFF);
    rd(8'hF0, 8'h00);
    att_a = 8'($urandom);
    att_b = 8'($urandom);
    wr(8'h18, att_a);
    wr(8'h19, att_b);
    cyc(2);
    chk(18'(atten_bypass_q), 18'({att_b, att_a}));
    // single mode on code 5 with the reading above its upper limit
    d = 10'($urandom_range(1019, 8));
    sample_val  <= d;
    chan_enable <= 18'h00221;
    batt_mode   <= 1'b1;
    wr(8'h83, 8'h01);
    wr(8'h45, d[9:2] - 8'h01);
    wr(8'h16, {5'h05, 3'b100});
    cyc(400);
    rd(8'h65, d[9:2]);
    rd(8'h80, 8'h20);
    chk(18'(alert_n_q), 18'h0);
    n_start = 0;
    cyc(400);
    chk(18'(n_start > 48), 18'h1);
    wr(8'h45, 8'hFF);
    cyc(200);
    rd(8'h80, 8'h20);
    rd(8'h80, 8'h00);
    cyc(3);
    chk(18'(alert_n_q), 18'h1);
    wr(8'h25, d[9:2] + 8'h01);
    cyc(200);
    rd(8'h80, 8'h20);
    rd(8'h80, 8'h20);
    wr(8'h25, 8'h00);
    // unassigned codes leave the converter idle
    for (int i = 0; i < 3; i++) begin
      wr(8'h16, {(i == 0) ? 5'h0F : (i == 1) ? 5'h12 : 5'h1F, 3'b100});
      cyc(120); // a reading already under way may need up to 96 cycles
      n_start = 0;
      cyc(200);
      chk(18'(n_start), 18'h0);
    end
    // single mode on the battery code
    d = 10'($urandom_range(1023, 0));
    sample_val <= d;
    wr(8'h16, 8'h04);
    cyc(100);
    chk(18'(batt_leg_q), 18'h1);
    rd(8'h60, d[9:2]);
    // round robin over codes 0, 5 and 9
    wr(8'h16, 8'h00);
    slots_seen = 0;
    rr_on = 1'b1;
    cyc(1500);
    rr_on = 1'b0;
    test_done;
  end
endmodule // adc_round_robin_sequencer_tb_top
